// [jt_pkg.sv]
// constants, types and the tap next-state function shared by both ends of the test port link
// assumes both ends compile against this package and meet in jt_link_if
// Operation
// - port starts reset, idle without clock edges
// - clock, mode, data inputs pulled high
// - floating mode select acts as one
// - floating data input shifts in ones
// - inputs on rising edge, outputs falling
// - state steered only by sampled mode select
// - state and instruction choose shift path
// - data out driven only while shifting
// - data out changes after falling edge
// - no separate asynchronous test reset input
// - five high mode edges force reset
// - state machine resets itself at power-up
// - unused board pins may float or tie
// - unused data out left unconnected
// - three-bit instruction register loaded serially
// - reset presets identification-read instruction
// - 32-bit identity, captured, shifted lsb first
`default_nettype none
package jt_pkg;
  // timing of the generated test clock
  localparam int MCLK_PERIOD_NS = 20;
  localparam int TCK_PERIOD_NS = 160;
  localparam int TCK_CYC = TCK_PERIOD_NS / MCLK_PERIOD_NS;
  localparam logic [2:0] TICK_SAMPLE = 3'(TCK_CYC / 2 - 1);
  localparam logic [2:0] TICK_RISE = 3'(TCK_CYC / 2);
  localparam logic [2:0] TICK_LAST = 3'(TCK_CYC - 1);
  // mode-select edges that reach reset from anywhere
  localparam int RST_TMS_EDGES = 5;

  // instruction register
  localparam int IR_W = 3;
  localparam logic [IR_W-1:0] IR_EXTEST = 3'h0;
  localparam logic [IR_W-1:0] IR_IDCODE = 3'h1;
  localparam logic [IR_W-1:0] IR_SAMPLE = 3'h2;
  localparam logic [IR_W-1:0] IR_BYPASS = 3'h7;
  localparam logic [IR_W-1:0] IR_CAPTURE = 3'h1;
  // identity register; value is arbitrary, bit 0 kept one
  localparam int ID_W = 32;
  localparam logic [ID_W-1:0] ID_CODE = 32'h5A5A_0C35;

  // host command kinds and tms walk patterns, sent lsb first
  localparam logic [1:0] CMD_RESET = 2'h0;
  localparam logic [1:0] CMD_IR = 2'h1;
  localparam logic [1:0] CMD_DR = 2'h2;
  localparam logic [7:0] SEQ_PRE_RST = 8'h1F;
  localparam logic [3:0] CNT_PRE_RST = 4'(RST_TMS_EDGES);
  localparam logic [7:0] SEQ_PRE_IR = 8'h03;
  localparam logic [3:0] CNT_PRE_IR = 4'h4;
  localparam logic [7:0] SEQ_PRE_DR = 8'h01;
  localparam logic [3:0] CNT_PRE_DR = 4'h3;
  localparam logic [7:0] SEQ_POST_RST = 8'h00;
  localparam logic [3:0] CNT_POST_RST = 4'h1;
  localparam logic [7:0] SEQ_POST_SCAN = 8'h01;
  localparam logic [3:0] CNT_POST_SCAN = 4'h2;
  localparam logic [5:0] LEN_MAX = 6'h20;

  typedef enum logic [3:0] {
    TAP_RESET = 4'h0, TAP_IDLE = 4'h1, TAP_SEL_DR = 4'h2, TAP_CAP_DR = 4'h3,
    TAP_SH_DR = 4'h4, TAP_EX1_DR = 4'h5, TAP_PA_DR = 4'h6, TAP_EX2_DR = 4'h7,
    TAP_UPD_DR = 4'h8, TAP_SEL_IR = 4'h9, TAP_CAP_IR = 4'hA, TAP_SH_IR = 4'hB,
    TAP_EX1_IR = 4'hC, TAP_PA_IR = 4'hD, TAP_EX2_IR = 4'hE, TAP_UPD_IR = 4'hF
  } jt_tap_t;

  typedef enum logic [2:0] {
    H_IDLE = 3'h0, H_PRE = 3'h1, H_SHIFT = 3'h2, H_POST = 3'h3, H_DONE = 3'h4
  } jt_phase_t;

  // sixteen-state controller walk, one step per rising edge
  function automatic jt_tap_t jt_tap_next(input jt_tap_t s, input logic tms);
    jt_tap_t n;
    n = TAP_RESET;
    unique case (s)
      TAP_RESET: n = tms ? TAP_RESET : TAP_IDLE;
      TAP_IDLE: n = tms ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_DR: n = tms ? TAP_SEL_IR : TAP_CAP_DR;
      TAP_CAP_DR: n = tms ? TAP_EX1_DR : TAP_SH_DR;
      TAP_SH_DR: n = tms ? TAP_EX1_DR : TAP_SH_DR;
      TAP_EX1_DR: n = tms ? TAP_UPD_DR : TAP_PA_DR;
      TAP_PA_DR: n = tms ? TAP_EX2_DR : TAP_PA_DR;
      TAP_EX2_DR: n = tms ? TAP_UPD_DR : TAP_SH_DR;
      TAP_UPD_DR: n = tms ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_IR: n = tms ? TAP_RESET : TAP_CAP_IR;
      TAP_CAP_IR: n = tms ? TAP_EX1_IR : TAP_SH_IR;
      TAP_SH_IR: n = tms ? TAP_EX1_IR : TAP_SH_IR;
      TAP_EX1_IR: n = tms ? TAP_UPD_IR : TAP_PA_IR;
      TAP_PA_IR: n = tms ? TAP_EX2_IR : TAP_PA_IR;
      TAP_EX2_IR: n = tms ? TAP_UPD_IR : TAP_SH_IR;
      TAP_UPD_IR: n = tms ? TAP_SEL_DR : TAP_IDLE;
    endcase
    return n;
  endfunction
endpackage
`default_nettype wire

// [jt_link_if.sv]
// test port pins between the host controller and the memory's tap
// assumes the host drives clock, mode and data in, the tap drives data out
`default_nettype none
interface jt_link_if;
  logic tck_d;
  logic tck_oe;
  logic tms_d;
  logic tms_oe;
  logic tdi_d;
  logic tdi_oe;
  logic tdo_d;
  logic tdo_oe;
  logic tck;
  logic tms;
  logic tdi;
  logic tdo;

  // pull-ups: an undriven input settles high
  assign tck = tck_oe ? tck_d : 1'b1;
  assign tms = tms_oe ? tms_d : 1'b1;
  assign tdi = tdi_oe ? tdi_d : 1'b1;
  // no pull on data out; a released pin shows the inverse so early sampling shows up
  assign tdo = tdo_oe ? tdo_d : ~tdo_d;

  modport host (output tck_d, tck_oe, tms_d, tms_oe, tdi_d, tdi_oe, input tdo);
  modport dev (input tck, tms, tdi, output tdo_d, tdo_oe);
endinterface
`default_nettype wire

// [jt_tdo_stage.sv]
// falling-edge output stage of the tap's serial data out
// assumes bit and enable come from rising-edge logic on the same test clock
`default_nettype none
module jt_tdo_stage (
  input wire logic tck_i,
  input wire logic ce_i,
  input wire logic bit_i,
  input wire logic en_i,
  output logic tdo_o,
  output logic tdo_oe_o
);
  typedef struct packed {
    logic tdo;
    logic oe;
  } jt_out_t;

  // power-up value keeps the pin released before any clock edge
  jt_out_t st_ff = '0;
  jt_out_t nxt_st;

  // next output level, enable only in shift states
  always_comb begin
    nxt_st = st_ff;
    nxt_st.tdo = bit_i;
    nxt_st.oe = en_i;
  end

  // half a cycle of margin for the controller's rising-edge sample
  always_ff @(negedge tck_i) begin
    if (ce_i) begin
      st_ff <= nxt_st;
    end
  end

  assign tdo_o = st_ff.tdo;
  assign tdo_oe_o = st_ff.oe;
endmodule
`default_nettype wire

// [jt_tap_dev.sv]
// memory-side test access port: controller, instruction, identity and bypass registers
// assumes the link clock comes from the host; rst_i and ce_i are synchronous to that clock
`default_nettype none
module jt_tap_dev
  import jt_pkg::*;
(
  jt_link_if.dev lnk,
  input wire logic rst_i,
  input wire logic ce_i,
  output logic [IR_W-1:0] instr_o,
  output logic in_reset_o
);
  typedef struct packed {
    jt_tap_t state;
    logic [IR_W-1:0] ir;
    logic [IR_W-1:0] ir_shr;
    logic [ID_W-1:0] dr;
    logic byp;
  } jt_dev_t;

  localparam jt_dev_t ST_INIT = '{state: TAP_RESET, ir: IR_IDCODE, ir_shr: IR_CAPTURE, dr: ID_CODE, byp: 1'b0};

  // no reset pin: the power-up value is the reset state
  jt_dev_t st_ff = ST_INIT;
  jt_dev_t nxt_st;
  logic id_sel;
  logic sel_bit;
  logic shift_en;

  // boundary chain is not modelled, so its instructions fall to bypass
  assign id_sel = (st_ff.ir == IR_IDCODE);

  // one register between data in and data out at a time
  always_comb begin
    if (st_ff.state == TAP_SH_IR) begin
      sel_bit = st_ff.ir_shr[0];
    end else if (id_sel) begin
      sel_bit = st_ff.dr[0];
    end else begin
      sel_bit = st_ff.byp;
    end
    shift_en = (st_ff.state == TAP_SH_DR) || (st_ff.state == TAP_SH_IR);
  end

  // controller step and register effects per rising edge
  always_comb begin
    nxt_st = st_ff;
    if (rst_i) begin
      nxt_st = ST_INIT;
    end else begin
      nxt_st.state = jt_tap_next(st_ff.state, lnk.tms);
      case (st_ff.state)
        TAP_RESET: begin
          nxt_st.ir = IR_IDCODE;
        end
        TAP_CAP_DR: begin
          if (id_sel) begin
            nxt_st.dr = ID_CODE;
          end else begin
            nxt_st.byp = 1'b0;
          end
        end
        TAP_SH_DR: begin
          if (id_sel) begin
            nxt_st.dr = {lnk.tdi, st_ff.dr[ID_W-1:1]};
          end else begin
            nxt_st.byp = lnk.tdi;
          end
        end
        TAP_CAP_IR: begin
          nxt_st.ir_shr = {1'b0, IR_CAPTURE[1:0]};
        end
        TAP_SH_IR: begin
          nxt_st.ir_shr = {lnk.tdi, st_ff.ir_shr[IR_W-1:1]};
        end
        TAP_UPD_IR: begin
          nxt_st.ir = st_ff.ir_shr;
        end
        default: begin
        end
      endcase
    end
  end

  // everything lives on the test clock; no memory clock involved
  always_ff @(posedge lnk.tck) begin
    if (ce_i) begin
      st_ff <= nxt_st;
    end
  end

  // output stage updates only on falling edges
  jt_tdo_stage u_tdo (
    .tck_i(lnk.tck),
    .ce_i(ce_i),
    .bit_i(sel_bit),
    .en_i(shift_en),
    .tdo_o(lnk.tdo_d),
    .tdo_oe_o(lnk.tdo_oe)
  );

  assign instr_o = st_ff.ir;
  assign in_reset_o = (st_ff.state == TAP_RESET);
endmodule
`default_nettype wire

// [jt_tap_host.sv]
// boundary-scan controller: reset walks and ir/dr scans on a divided test clock
// assumes commands come from logic on mclk_i; every command starts and ends in run-test/idle
`default_nettype none
module jt_tap_host
  import jt_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  jt_link_if.host lnk,
  input wire logic cmd_valid_i,
  output logic cmd_ready_o,
  input wire logic [1:0] cmd_kind_i,
  input wire logic [5:0] cmd_len_i,
  input wire logic [ID_W-1:0] cmd_data_i,
  output logic rsp_valid_o,
  output logic [ID_W-1:0] rsp_data_o
);
  typedef struct packed {
    jt_phase_t phase;
    logic [2:0] tick;
    logic [7:0] seq;
    logic [3:0] seq_cnt;
    logic [1:0] kind;
    logic [5:0] len;
    logic [5:0] idx;
    logic [ID_W-1:0] tx;
    logic [ID_W-1:0] cap;
    logic tck;
    logic tms;
    logic tdi;
    logic oe;
    logic sync1;
    logic sync2;
    logic rsp_valid;
    logic [ID_W-1:0] rsp_data;
  } jt_host_t;

  jt_host_t st_ff;
  jt_host_t nxt_st;
  logic last_bit;

  assign last_bit = (st_ff.idx == (st_ff.len - 6'h01));

  // command sequencing, one test clock period per eight mclk ticks
  always_comb begin
    nxt_st = st_ff;
    nxt_st.rsp_valid = 1'b0;
    nxt_st.oe = 1'b1;
    // data out crosses from the test clock domain
    nxt_st.sync1 = lnk.tdo;
    nxt_st.sync2 = st_ff.sync1;
    unique case (st_ff.phase)
      H_IDLE: begin
        nxt_st.tick = 3'h0;
        nxt_st.tck = 1'b0;
        if (cmd_valid_i) begin
          nxt_st.kind = cmd_kind_i;
          nxt_st.tx = cmd_data_i;
          nxt_st.cap = '0;
          nxt_st.idx = 6'h00;
          // zero and oversize lengths are clamped to a legal scan
          if (cmd_len_i == 6'h00) begin
            nxt_st.len = 6'h01;
          end else if (cmd_len_i > LEN_MAX) begin
            nxt_st.len = LEN_MAX;
          end else begin
            nxt_st.len = cmd_len_i;
          end
          nxt_st.phase = H_PRE;
          if (cmd_kind_i == CMD_IR) begin
            nxt_st.seq = SEQ_PRE_IR;
            nxt_st.seq_cnt = CNT_PRE_IR;
          end else if (cmd_kind_i == CMD_DR) begin
            nxt_st.seq = SEQ_PRE_DR;
            nxt_st.seq_cnt = CNT_PRE_DR;
          end else begin
            nxt_st.seq = SEQ_PRE_RST;
            nxt_st.seq_cnt = CNT_PRE_RST;
          end
        end
      end
      H_PRE, H_SHIFT, H_POST: begin
        nxt_st.tick = st_ff.tick + 3'h1;
        // bits change while the clock is low, ahead of the rising edge
        if (st_ff.tick == 3'h0) begin
          nxt_st.tck = 1'b0;
          if (st_ff.phase == H_SHIFT) begin
            nxt_st.tms = last_bit;
            nxt_st.tdi = st_ff.tx[0];
          end else begin
            nxt_st.tms = st_ff.seq[0];
          end
        end
        if ((st_ff.tick == TICK_SAMPLE) && (st_ff.phase == H_SHIFT)) begin
          nxt_st.cap = {st_ff.sync2, st_ff.cap[ID_W-1:1]};
        end
        if (st_ff.tick == TICK_RISE) begin
          nxt_st.tck = 1'b1;
        end
        if (st_ff.tick == TICK_LAST) begin
          nxt_st.tick = 3'h0;
          if (st_ff.phase == H_SHIFT) begin
            nxt_st.tx = {1'b0, st_ff.tx[ID_W-1:1]};
            nxt_st.idx = st_ff.idx + 6'h01;
            if (last_bit) begin
              nxt_st.phase = H_POST;
              nxt_st.seq = SEQ_POST_SCAN;
              nxt_st.seq_cnt = CNT_POST_SCAN;
            end
          end else begin
            nxt_st.seq = {1'b0, st_ff.seq[7:1]};
            nxt_st.seq_cnt = st_ff.seq_cnt - 4'h1;
            if (st_ff.seq_cnt == 4'h1) begin
              if (st_ff.phase == H_POST) begin
                nxt_st.phase = H_DONE;
              end else if (st_ff.kind == CMD_IR || st_ff.kind == CMD_DR) begin
                nxt_st.phase = H_SHIFT;
              end else begin
                nxt_st.phase = H_POST;
                nxt_st.seq = SEQ_POST_RST;
                nxt_st.seq_cnt = CNT_POST_RST;
              end
            end
          end
        end
      end
      H_DONE: begin
        // right-align the captured bits, first bit out lands in bit 0
        nxt_st.rsp_data = st_ff.cap >> (LEN_MAX - st_ff.len);
        nxt_st.rsp_valid = 1'b1;
        nxt_st.phase = H_IDLE;
      end
      default: begin
        nxt_st.phase = H_IDLE;
      end
    endcase
  end

  // register the whole state; pins released while in reset
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      st_ff <= '0;
      st_ff.phase <= H_IDLE;
    end else if (ce_i) begin
      st_ff <= nxt_st;
    end
  end

  assign lnk.tck_d = st_ff.tck;
  assign lnk.tms_d = st_ff.tms;
  assign lnk.tdi_d = st_ff.tdi;
  assign lnk.tck_oe = st_ff.oe;
  assign lnk.tms_oe = st_ff.oe;
  assign lnk.tdi_oe = st_ff.oe;
  assign cmd_ready_o = (st_ff.phase == H_IDLE);
  assign rsp_valid_o = st_ff.rsp_valid;
  assign rsp_data_o = st_ff.rsp_data;
endmodule
`default_nettype wire

// [jt_link_properties.sv]
// concurrent checks on the test port pins between host and tap
// assumes the bench feeds the pins of one jt_link_if plus the host clock and reset
`default_nettype none
module jt_link_properties (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  input wire logic tdo_d,
  input wire logic tdo_oe
);
  logic [1:0] fall_ff;

  // data out as seen while the clock is low; a negedge copy would race the stage's own update
  always_ff @(posedge mclk_i) begin
    if (!tck) begin
      fall_ff <= {tdo_oe, tdo_d};
    end
  end

  // a rising edge must find data out untouched since the fall
  tdo_hold_a: assert property (@(posedge tck) disable iff (rst_i) {tdo_oe, tdo_d} == fall_ff)
    else $error("data out changed between falling and rising edge");
  // five high mode samples leave the tap far from any shift
  reset_walk_a: assert property (@(posedge tck) disable iff (rst_i) tms [*5] |=> !tdo_oe [*4])
    else $error("data out driven too soon after reset walk");
  // shifting is only entered with mode select low and only left with it high
  shift_enter_a: assert property (@(posedge tck) disable iff (rst_i) $rose(tdo_oe) |-> !$past(tms))
    else $error("data out enabled without a shift entry");
  shift_leave_a: assert property (@(posedge tck) disable iff (rst_i) $fell(tdo_oe) |-> $past(tms))
    else $error("data out released without a shift exit");
  // power-up state is the reset state, so no early shift
  power_quiet_a: assert property (@(posedge tck) disable iff (rst_i) $fell(rst_i) |-> !tdo_oe [*4])
    else $error("data out driven right after power-up");
  // host may move mode and data only while the clock is low
  tms_steady_a: assert property (@(posedge mclk_i) disable iff (rst_i) tck && $past(tck) |-> $stable(tms))
    else $error("mode select moved while test clock high");
  tdi_steady_a: assert property (@(posedge mclk_i) disable iff (rst_i) tck && $past(tck) |-> $stable(tdi))
    else $error("data in moved while test clock high");
  // the tap output must not respond to a rising edge
  rise_quiet_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    $rose(tck) |-> $stable(tdo_d) && $stable(tdo_oe))
    else $error("data out moved on a rising test clock");
endmodule
`default_nettype wire

// [sram_jtag_tap_port_test.sv]
// bench: host and tap joined back to back, plus a second tap driven by hand
// assumes the jt_ package, interface, design modules and checker are compiled first
`default_nettype none
module sram_jtag_tap_port_test import jt_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  int stall_cyc = 0;
  logic cmd_valid = 1'b0;
  logic [1:0] cmd_kind = 2'h0;
  logic [5:0] cmd_len = 6'h01;
  logic [31:0] cmd_data = 32'h0;
  logic cmd_ready;
  logic rsp_valid;
  logic [31:0] rsp_data;
  logic [2:0] instr;
  logic [2:0] instr2;
  logic in_reset;
  logic in_reset2;
  int errors = 0;
  int checks_done = 0;
  int seed = 32'hAB56B869;

  jt_link_if lnk();
  jt_link_if lnk2();
  jt_tap_host jt_tap_host_i (.mclk_i(mclk), .rst_i(rst), .ce_i(ce), .lnk(lnk), .cmd_valid_i(cmd_valid),
    .cmd_ready_o(cmd_ready), .cmd_kind_i(cmd_kind), .cmd_len_i(cmd_len), .cmd_data_i(cmd_data),
    .rsp_valid_o(rsp_valid), .rsp_data_o(rsp_data));
  jt_tap_dev jt_tap_dev_i (.lnk(lnk), .rst_i(rst), .ce_i(1'b1), .instr_o(instr), .in_reset_o(in_reset));
  // second tap shares the bench reset only to cover the start-up edge of its undriven clock
  jt_tap_dev jt_tap_dev_i2 (.lnk(lnk2), .rst_i(rst), .ce_i(1'b1), .instr_o(instr2), .in_reset_o(in_reset2));
  jt_link_properties jt_link_properties_i (.mclk_i(mclk), .rst_i(rst), .tck(lnk.tck), .tms(lnk.tms),
    .tdi(lnk.tdi), .tdo_d(lnk.tdo_d), .tdo_oe(lnk.tdo_oe));

  always #10 mclk = ~mclk;

  // compare and count
  task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic report_and_stop;
    if (errors == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // answers are right-aligned, so only the low len bits count
  function automatic logic [31:0] len_mask(input logic [5:0] len);
    return (len >= 6'h20) ? 32'hFFFFFFFF : ((32'h1 << len) - 32'h1);
  endfunction

  // identity under the read instruction, else one bypass bit capturing zero
  function automatic logic [31:0] dr_exp(input logic [2:0] ir, input logic [5:0] len, input logic [31:0] d);
    return ((ir == IR_IDCODE) ? ID_CODE : {d[30:0], 1'b0}) & len_mask(len);
  endfunction

  // one host command; the answer must come after exactly the walk's periods
  task automatic run_cmd(input logic [1:0] kind, input logic [5:0] len, input logic [31:0] d, input int periods);
    int n;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 50) begin
      @(posedge mclk);
      #1;
      n++;
    end
    cmd_valid = 1'b1;
    cmd_kind = kind;
    cmd_len = len;
    cmd_data = d;
    @(posedge mclk);
    #1;
    cmd_valid = 1'b0;
    n = 0;
    // a clock-enable gap early in the walk must stretch it cycle for cycle
    if (stall_cyc > 0) begin
      repeat (3) @(posedge mclk);
      #1;
      ce = 1'b0;
      repeat (stall_cyc) @(posedge mclk);
      #1;
      ce = 1'b1;
      n = 3 + stall_cyc;
    end
    while (rsp_valid !== 1'b1 && n < 400) begin
      @(posedge mclk);
      #1;
      n++;
    end
    chk("answer delay", 32'(n), 32'(8 * periods + 1 + stall_cyc));
  endtask

  // one test clock period on the hand-driven pins; data out sampled in the low half
  task automatic step2(input logic m, input logic fl, output logic so);
    lnk2.tck_d = 1'b0;
    lnk2.tms_oe = !fl;
    lnk2.tms_d = m;
    #40;
    so = lnk2.tdo;
    #40;
    lnk2.tck_d = 1'b1;
    #80;
  endtask

  initial begin
    logic [2:0] codes [4] = '{IR_IDCODE, IR_EXTEST, IR_SAMPLE, IR_BYPASS};
    logic [2:0] code;
    logic [5:0] len;
    logic [31:0] d;
    logic [39:0] seen;
    logic s;
    // let the second tap's reset settle before its pins leave the unknown level
    #1;
    lnk2.tck_oe = 1'b0;
    lnk2.tck_d = 1'b1;
    lnk2.tms_oe = 1'b0;
    lnk2.tms_d = 1'b0;
    lnk2.tdi_oe = 1'b0;
    lnk2.tdi_d = 1'b0;
    repeat (20) @(posedge mclk);
    #1;
    chk("unclocked tap reset", 32'(in_reset2), 32'h1);
    chk("unclocked tap out", 32'(lnk2.tdo_oe), 32'h0);
    chk("tap reset at start", 32'(in_reset), 32'h1);
    rst = 1'b0;
    run_cmd(CMD_RESET, 6'h01, 32'h0, 6);
    chk("instr at start", 32'(instr), 32'(IR_IDCODE));
    chk("tap idle after walk", 32'(in_reset), 32'h0);
    d = $random(seed);
    stall_cyc = 5;
    run_cmd(CMD_DR, 6'h20, d, 37);
    stall_cyc = 0;
    chk("identity", rsp_data, ID_CODE);
    // every named code first, then random ones; length corners 1 and 32
    for (int i = 0; i < 14; i++) begin
      code = (i < 4) ? codes[i] : 3'($random(seed));
      len = (i == 4) ? 6'h01 : (i == 5) ? 6'h20 : 6'(({$random(seed)} % 32) + 1);
      d = $random(seed);
      run_cmd(CMD_IR, 6'h03, {29'h0, code}, 9);
      chk("ir capture", rsp_data & 32'h7, 32'h1);
      chk("instr", 32'(instr), 32'(code));
      run_cmd(CMD_DR, len, d, 5 + int'(len));
      chk("dr scan", rsp_data & len_mask(len), dr_exp(code, len, d));
    end
    run_cmd(CMD_IR, 6'h03, {29'h0, IR_BYPASS}, 9);
    run_cmd(CMD_RESET, 6'h01, 32'h0, 6);
    chk("instr after walk", 32'(instr), 32'(IR_IDCODE));
    // hand-driven tap, phase unrelated to the host clock
    #7;
    lnk2.tck_oe = 1'b1;
    step2(1'b0, 1'b0, s);
    chk("tap left reset", 32'(in_reset2), 32'h0);
    step2(1'b1, 1'b0, s);
    repeat (5) step2(1'b0, 1'b1, s);
    chk("floating mode reset", 32'(in_reset2), 32'h1);
    chk("floating mode instr", 32'(instr2), 32'(IR_IDCODE));
    step2(1'b0, 1'b0, s);
    step2(1'b1, 1'b0, s);
    step2(1'b0, 1'b0, s);
    step2(1'b0, 1'b0, s);
    // data in floats: ones must follow the identity
    for (int j = 0; j < 40; j++) begin
      step2(1'b0, 1'b0, s);
      seen[j] = s;
    end
    chk("floating shift id", seen[31:0], ID_CODE);
    chk("floating data fill", 32'(seen[39:32]), 32'hFF);
    chk("out in shift", 32'(lnk2.tdo_oe), 32'h1);
    step2(1'b1, 1'b0, s);
    step2(1'b1, 1'b0, s);
    chk("out after shift", 32'(lnk2.tdo_oe), 32'h0);
    report_and_stop;
  end

  // the tests need about a tenth of this span
  initial begin
    #1000000;
    errors++;
    report_and_stop;
  end
endmodule
`default_nettype wire
